// ==== hw/vfd_ctrl.sv ====
// Summary of operation
// - Two general outputs hold levels statically
// - Port bit one drives high, zero low
// - Reset drives both general outputs low
// - Duty value N gives (8+N)/16 on-time
// - Reset clears duty to minimum 8/16
// - Digit value 0 is 16, else 8+N
// - Reset clears digit count to sixteen
// - Off forces segments low, on forces high
// - Reset sets off flag, clears on flag
// - Both flags set drives segments high
// - Light override leaves general outputs alone
`timescale 1ns/100ps
`default_nettype none
module vfd_ctrl #(
    parameter int SEG_W = vfd_pkg::SEG_WIDTH,
    parameter int SYM_W = vfd_pkg::SYM_WIDTH,
    parameter int TICK_CYCLES = vfd_pkg::SLOT_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic [SEG_W-1:0] segData,
    input wire logic [SYM_W-1:0] symData,
    output logic [SEG_W-1:0] segment_outputs,
    output logic [SYM_W-1:0] symbol_outputs,
    output logic [15:0] grid_outputs,
    output logic [3:0] scanGrid,
    output logic general_output_one,
    output logic general_output_two
);
    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic cmdWrite;
    logic [3:0] cmdSel;
    logic isGpo;
    logic isDuty;
    logic isDigits;
    logic isLights;
    logic cmdKnown;

    assign cmdWrite = regWrStb && (regAddr == vfd_pkg::REG_CMD);
    assign cmdSel = regWrData[vfd_pkg::CMD_SEL_MSB:vfd_pkg::CMD_SEL_LSB];
    assign isGpo = cmdWrite && (cmdSel == vfd_pkg::CMD_SEL_GPO);
    assign isDuty = cmdWrite && (cmdSel == vfd_pkg::CMD_SEL_DUTY);
    assign isDigits = cmdWrite && (cmdSel == vfd_pkg::CMD_SEL_DIGITS);
    assign isLights = cmdWrite && (cmdSel == vfd_pkg::CMD_SEL_LIGHTS);
    assign cmdKnown = isGpo || isDuty || isDigits || isLights;

    // ------------------------------------------------------------
    // Setting registers
    // ------------------------------------------------------------
    logic [1:0] gpo_reg;
    logic [1:0] gpo_next;
    logic [2:0] duty_reg;
    logic [2:0] duty_next;
    logic [2:0] digits_reg;
    logic [2:0] digits_next;
    logic lightsOff_reg;
    logic lightsOff_next;
    logic lightsOn_reg;
    logic lightsOn_next;

    // Only the data bits are taken; the rest of the byte is don't care
    assign gpo_next = isGpo ? {regWrData[vfd_pkg::GPO_TWO_BIT], regWrData[vfd_pkg::GPO_ONE_BIT]}
                            : gpo_reg;
    assign duty_next = isDuty ? regWrData[vfd_pkg::VAL_MSB:0] : duty_reg;
    assign digits_next = isDigits ? regWrData[vfd_pkg::VAL_MSB:0] : digits_reg;
    assign lightsOff_next = isLights ? regWrData[vfd_pkg::LIGHTS_OFF_BIT] : lightsOff_reg;
    assign lightsOn_next = isLights ? regWrData[vfd_pkg::LIGHTS_ON_BIT] : lightsOn_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gpo_reg <= vfd_pkg::GPO_RESET;
            duty_reg <= vfd_pkg::DUTY_RESET;
            digits_reg <= vfd_pkg::DIGITS_RESET;
            lightsOff_reg <= vfd_pkg::LIGHTS_OFF_RESET;
            lightsOn_reg <= vfd_pkg::LIGHTS_ON_RESET;
        end else begin
            gpo_reg <= gpo_next;
            duty_reg <= duty_next;
            digits_reg <= digits_next;
            lightsOff_reg <= lightsOff_next;
            lightsOn_reg <= lightsOn_next;
        end
    end

    // ------------------------------------------------------------
    // General outputs
    // ------------------------------------------------------------
    // Static levels, never touched by scanning or by the light override
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            general_output_one <= 1'b0;
            general_output_two <= 1'b0;
        end else begin
            general_output_one <= gpo_next[vfd_pkg::GPO_ONE_BIT];
            general_output_two <= gpo_next[vfd_pkg::GPO_TWO_BIT];
        end
    end

    // ------------------------------------------------------------
    // Grid scanner
    // ------------------------------------------------------------
    // Settings change the scan at once; the host is expected to set
    // them while the display is dark, so no glitch guard is kept here
    vfd_scan_if scanIf ();
    assign scanIf.duty = duty_reg;
    assign scanIf.digits = digits_reg;

    vfd_grid_scan #(
        .TICK_CYCLES(TICK_CYCLES)
    ) uScan (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .scanIf(scanIf.scan)
    );

    // ------------------------------------------------------------
    // Segment and symbol drive with all-lights override
    // ------------------------------------------------------------
    logic [SEG_W-1:0] segSel;
    logic [SYM_W-1:0] symSel;

    // All-on wins over all-off
    assign segSel = lightsOn_reg ? {SEG_W{1'b1}} : (lightsOff_reg ? {SEG_W{1'b0}} : segData);
    assign symSel = lightsOn_reg ? {SYM_W{1'b1}} : (lightsOff_reg ? {SYM_W{1'b0}} : symData);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            segment_outputs <= '0;
            symbol_outputs <= '0;
            grid_outputs <= 16'h0;
            scanGrid <= 4'h0;
        end else begin
            segment_outputs <= segSel;
            symbol_outputs <= symSel;
            grid_outputs <= scanIf.gridOut;
            scanGrid <= scanIf.gridIdx;
        end
    end

    // ------------------------------------------------------------
    // Command statistics
    // ------------------------------------------------------------
    logic [7:0] cmdOk_reg;
    logic [7:0] cmdBad_reg;
    logic [7:0] lastCmd_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmdOk_reg <= 8'h0;
            cmdBad_reg <= 8'h0;
            lastCmd_reg <= 8'h0;
        end else if (cmdWrite) begin
            lastCmd_reg <= regWrData;
            if (cmdKnown) begin
                cmdOk_reg <= cmdOk_reg + 8'h1;
            end else begin
                cmdBad_reg <= cmdBad_reg + 8'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [7:0] rdMux;

    always_comb begin
        case (regAddr)
            vfd_pkg::REG_GPO: rdMux = {6'h0, gpo_reg};
            vfd_pkg::REG_DUTY: rdMux = {5'h0, duty_reg};
            vfd_pkg::REG_DIGITS: rdMux = {5'h0, digits_reg};
            vfd_pkg::REG_LIGHTS: rdMux = {6'h0, lightsOn_reg, lightsOff_reg};
            vfd_pkg::REG_SCAN: rdMux = {4'h0, scanIf.gridIdx};
            vfd_pkg::REG_CMD_OK: rdMux = cmdOk_reg;
            vfd_pkg::REG_CMD_BAD: rdMux = cmdBad_reg;
            vfd_pkg::REG_LAST_CMD: rdMux = lastCmd_reg;
            default: rdMux = 8'h0;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !regRdStb) begin
            regRdData <= 8'h0;
        end else begin
            regRdData <= rdMux;
        end
    end
endmodule : vfd_ctrl
`default_nettype wire

// ==== hw/vfd_pkg.sv ====
`default_nettype none
package vfd_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SLOT_TICK_NS = 1000;
    localparam int SLOT_TICK_CYCLES = (SLOT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Geometry
    localparam int GRID_COUNT = 16;
    localparam int SEG_WIDTH = 35;
    localparam int SYM_WIDTH = 2;
    localparam logic [3:0] GRID_BASE = 4'h7;
    localparam logic [3:0] GRID_LAST_FULL = 4'hf;

    // Command byte layout
    localparam int CMD_SEL_MSB = 7;
    localparam int CMD_SEL_LSB = 4;
    localparam logic [3:0] CMD_SEL_GPO = 4'h4;
    localparam logic [3:0] CMD_SEL_DUTY = 4'h5;
    localparam logic [3:0] CMD_SEL_DIGITS = 4'h6;
    localparam logic [3:0] CMD_SEL_LIGHTS = 4'h7;
    localparam int GPO_ONE_BIT = 0;
    localparam int GPO_TWO_BIT = 1;
    localparam int VAL_MSB = 2;
    localparam int LIGHTS_OFF_BIT = 0;
    localparam int LIGHTS_ON_BIT = 1;

    // Register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_GPO = 4'h1;
    localparam logic [3:0] REG_DUTY = 4'h2;
    localparam logic [3:0] REG_DIGITS = 4'h3;
    localparam logic [3:0] REG_LIGHTS = 4'h4;
    localparam logic [3:0] REG_SCAN = 4'h5;
    localparam logic [3:0] REG_CMD_OK = 4'h6;
    localparam logic [3:0] REG_CMD_BAD = 4'h7;
    localparam logic [3:0] REG_LAST_CMD = 4'h8;

    // Reset values
    localparam logic [1:0] GPO_RESET = 2'h0;
    localparam logic [2:0] DUTY_RESET = 3'h0;
    localparam logic [2:0] DIGITS_RESET = 3'h0;
    localparam logic LIGHTS_OFF_RESET = 1'h1;
    localparam logic LIGHTS_ON_RESET = 1'h0;
endpackage : vfd_pkg
`default_nettype wire

// ==== hw/vfd_scan_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface vfd_scan_if;
    logic [2:0] duty;
    logic [2:0] digits;
    logic [3:0] gridIdx;
    logic [15:0] gridOut;
    logic slotStart;

    modport ctrl (output duty, output digits, input gridIdx, input gridOut, input slotStart);
    modport scan (input duty, input digits, output gridIdx, output gridOut, output slotStart);
endinterface : vfd_scan_if
`default_nettype wire

// ==== hw/vfd_grid_scan.sv ====
`timescale 1ns/100ps
`default_nettype none
module vfd_grid_scan #(
    parameter int TICK_CYCLES = vfd_pkg::SLOT_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    vfd_scan_if.scan scanIf
);
    // ------------------------------------------------------------
    // Slot tick divider
    // ------------------------------------------------------------
    logic [15:0] divCnt_reg;
    logic tick;
    assign tick = (divCnt_reg == 16'(TICK_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (sys_rst || tick) begin
            divCnt_reg <= 16'h0;
        end else begin
            divCnt_reg <= divCnt_reg + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Grid sequencing: sixteen ticks per grid slot
    // ------------------------------------------------------------
    logic [3:0] phase_reg;
    logic [3:0] grid_reg;
    logic [3:0] lastGrid;
    logic [3:0] onTicks;
    logic slotEnd;
    logic wrapGrid;
    logic gridOn;

    // Value 0 scans all sixteen grids, N scans grids 0..7+N
    assign lastGrid = (scanIf.digits == vfd_pkg::DIGITS_RESET) ? vfd_pkg::GRID_LAST_FULL
                                                                 : ({1'b0, scanIf.digits} + vfd_pkg::GRID_BASE);
    // On-time is 8+N of the sixteen ticks
    assign onTicks = {1'b1, scanIf.duty};
    assign slotEnd = tick && (phase_reg == 4'hf);
    // A shrunk count pulls an out-of-range index back to grid 0 at the end of the current slot
    assign wrapGrid = (grid_reg >= lastGrid);
    assign gridOn = (phase_reg < onTicks);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_reg <= 4'h0;
            grid_reg <= 4'h0;
        end else if (tick) begin
            phase_reg <= phase_reg + 4'h1;
            if (slotEnd) begin
                grid_reg <= wrapGrid ? 4'h0 : grid_reg + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registered grid drive
    // ------------------------------------------------------------
    logic [15:0] gridOut_reg;
    logic slotStart_reg;
    genvar g;
    generate
        for (g = 0; g < vfd_pkg::GRID_COUNT; g++) begin : gGrid
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    gridOut_reg[g] <= 1'b0;
                end else begin
                    gridOut_reg[g] <= gridOn && (grid_reg == 4'(g));
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            slotStart_reg <= 1'b0;
        end else begin
            slotStart_reg <= slotEnd;
        end
    end

    assign scanIf.gridOut = gridOut_reg;
    assign scanIf.gridIdx = grid_reg;
    assign scanIf.slotStart = slotStart_reg;
endmodule : vfd_grid_scan
`default_nettype wire

// ==== dv/vfd_ctrl_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module vfd_ctrl_properties #(
    parameter int SEG_W = 35,
    parameter int SYM_W = 2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic [SEG_W-1:0] segData,
    input wire logic [SEG_W-1:0] segment_outputs,
    input wire logic [SYM_W-1:0] symbol_outputs,
    input wire logic [15:0] grid_outputs,
    input wire logic general_output_one,
    input wire logic general_output_two
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic cmdWr = regWrStb && regAddr == vfd_pkg::REG_CMD;
    wire logic [3:0] cmdSel = regWrData[7:4];
    wire logic gpoWr = cmdWr && cmdSel == vfd_pkg::CMD_SEL_GPO;
    wire logic lightsWr = cmdWr && cmdSel == vfd_pkg::CMD_SEL_LIGHTS;
    wire logic [1:0] gpoPins = {general_output_two, general_output_one};
    sequence setThenRead(logic [3:0] sel, logic [3:0] addr);
        cmdWr && cmdSel == sel ##1 !regWrStb ##1 regRdStb && regAddr == addr;
    endsequence
    gpo_write_a: assert property (gpoWr |=> gpoPins == 2'($past(regWrData)))
        else $error("general outputs differ from command bits");
    gpo_hold_a: assert property (!gpoWr |=> $stable(gpoPins))
        else $error("general outputs moved without their command");
    gpo_reset_a: assert property (disable iff (1'b0) sys_rst |=> gpoPins == 2'h0)
        else $error("general outputs not low after reset");
    lights_reset_a: assert property (disable iff (1'b0) sys_rst |=> segment_outputs == '0 && symbol_outputs == '0)
        else $error("segments not low after reset");
    lights_on_a: assert property (lightsWr && regWrData[1] |-> ##2 &segment_outputs && &symbol_outputs)
        else $error("all-on did not drive segments high");
    lights_off_a: assert property (lightsWr && regWrData[1:0] == 2'h1 |-> ##2 segment_outputs == '0)
        else $error("all-off did not drive segments low");
    lights_normal_a: assert property (lightsWr && regWrData[1:0] == 2'h0 |-> ##2 segment_outputs == $past(segData))
        else $error("normal mode segments differ from data");
    duty_read_a: assert property (setThenRead(vfd_pkg::CMD_SEL_DUTY, vfd_pkg::REG_DUTY)
        |=> regRdData == ($past(regWrData, 3) & 8'h07)) else $error("duty readback wrong");
    digits_read_a: assert property (setThenRead(vfd_pkg::CMD_SEL_DIGITS, vfd_pkg::REG_DIGITS)
        |=> regRdData == ($past(regWrData, 3) & 8'h07)) else $error("digit count readback wrong");
    grid_single_a: assert property ($onehot0(grid_outputs))
        else $error("more than one grid driven");
endmodule : vfd_ctrl_properties
bind vfd_ctrl vfd_ctrl_properties #(.SEG_W(SEG_W), .SYM_W(SYM_W)) vfd_ctrl_properties_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .segData(segData),
    .segment_outputs(segment_outputs), .symbol_outputs(symbol_outputs), .grid_outputs(grid_outputs),
    .general_output_one(general_output_one), .general_output_two(general_output_two)
);
`default_nettype wire

// ==== dv/vfd_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module vfd_host_model (
    input wire logic ref_clk,
    output logic [3:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrStb,
    output logic regRdStb,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
    end
    // One byte per command, select in the upper nibble; data stays put after the strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        @(negedge ref_clk);
        d = regRdData;
    endtask : rd
endmodule : vfd_host_model
`default_nettype wire

// ==== dv/tb_vfd_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_vfd_ctrl;
    localparam int T = 2;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData, rdVal;
    logic regWrStb, regRdStb, general_output_one, general_output_two;
    logic [34:0] segData = '0;
    logic [34:0] segment_outputs, expSeg;
    logic [1:0] symData = '0;
    logic [1:0] symbol_outputs;
    logic [15:0] grid_outputs;
    logic [3:0] scanGrid;
    int miscompares = 0;
    int num_checks = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        segData <= segData + 35'h1;
        symData <= symData + 2'h1;
    end
    vfd_host_model vfd_host_model_i (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
    vfd_ctrl #(.TICK_CYCLES(T)) vfd_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .segData(segData), .symData(symData), .segment_outputs(segment_outputs),
        .symbol_outputs(symbol_outputs), .grid_outputs(grid_outputs), .scanGrid(scanGrid),
        .general_output_one(general_output_one), .general_output_two(general_output_two));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
        vfd_host_model_i.rd(a, rdVal);
        chk(64'(rdVal), 64'(exp));
    endtask : rdChk
    task automatic resetChk();
        @(negedge ref_clk);
        chk(64'({general_output_two, general_output_one, segment_outputs}), 64'h0);
        rdChk(vfd_pkg::REG_CMD_OK, 8'h00);
        rdChk(vfd_pkg::REG_DUTY, 8'h00);
        rdChk(vfd_pkg::REG_DIGITS, 8'h00);
        rdChk(vfd_pkg::REG_LIGHTS, 8'h01);
    endtask : resetChk
    // Window of 576 cycles is 18 whole slots, and two whole scan periods when nine grids are scanned
    task automatic gridChk(input logic [2:0] duty, input logic [2:0] dig, input logic [15:0] mask, input int exp);
        int cnt;
        int beyond;
        int atLast;
        logic [3:0] last;
        // Last scanned index: 0 means all sixteen, N means grids up to 7+N
        last = (dig == 3'h0) ? 4'hf : 4'h7 + 4'(dig);
        vfd_host_model_i.wr(vfd_pkg::REG_CMD, {vfd_pkg::CMD_SEL_DUTY, 1'b0, duty});
        vfd_host_model_i.wr(vfd_pkg::REG_CMD, {vfd_pkg::CMD_SEL_DIGITS, 1'b0, dig});
        repeat (64) @(posedge ref_clk);
        cnt = 0;
        beyond = 0;
        atLast = 0;
        repeat (576) begin
            @(negedge ref_clk);
            if ((grid_outputs & mask) != 16'h0) cnt++;
            if (scanGrid > last) beyond++;
            if (scanGrid == last) atLast++;
        end
        chk(64'(cnt), 64'(exp));
        chk(64'(beyond), 64'h0);
        // Nine grids: the window holds two whole scans, one slot each on the last grid
        if (dig == 3'h1) begin
            chk(64'(atLast), 64'(2 * 16 * T));
        end
    endtask : gridChk
    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        resetChk();
        for (int v = 0; v < 4; v++) begin
            vfd_host_model_i.wr(vfd_pkg::REG_CMD, {vfd_pkg::CMD_SEL_GPO, 4'hc | 4'(v)});
            @(negedge ref_clk);
            chk(64'({general_output_two, general_output_one}), 64'(v));
            rdChk(vfd_pkg::REG_GPO, 8'(v));
        end
        for (int n = 0; n < 8; n++) begin
            vfd_host_model_i.wr(vfd_pkg::REG_CMD, {vfd_pkg::CMD_SEL_DUTY, 4'h8 | 4'(n)});
            rdChk(vfd_pkg::REG_DUTY, 8'(n));
            vfd_host_model_i.wr(vfd_pkg::REG_CMD, {vfd_pkg::CMD_SEL_DIGITS, 4'h8 | 4'(n)});
            rdChk(vfd_pkg::REG_DIGITS, 8'(n));
        end
        gridChk(3'h0, 3'h0, 16'hffff, 18 * 8 * T);
        gridChk(3'h7, 3'h0, 16'hffff, 18 * 15 * T);
        gridChk(3'h7, 3'h1, 16'h0100, 2 * 15 * T);
        gridChk(3'h7, 3'h1, 16'hfe00, 0);
        gridChk(3'h3, 3'h7, 16'h8000, 0);
        // Duty and digit count are settled above before the display is lit
        for (int v = 0; v < 4; v++) begin
            vfd_host_model_i.wr(vfd_pkg::REG_CMD, {vfd_pkg::CMD_SEL_LIGHTS, 4'h4 | 4'(v)});
            @(posedge ref_clk);
            @(negedge ref_clk);
            expSeg = v[1] ? '1 : (v == 1 ? '0 : segData - 35'h1);
            chk(64'(segment_outputs), 64'(expSeg));
            chk(64'(symbol_outputs), 64'(v[1] ? 2'h3 : (v == 1 ? 2'h0 : symData - 2'h1)));
            chk(64'({general_output_two, general_output_one}), 64'h3);
            rdChk(vfd_pkg::REG_LIGHTS, 8'(v));
        end
        vfd_host_model_i.wr(vfd_pkg::REG_CMD, 8'h20);
        vfd_host_model_i.wr(vfd_pkg::REG_GPO, 8'h40);
        rdChk(vfd_pkg::REG_GPO, 8'h03);
        rdChk(4'hf, 8'h00);
        // One unknown select so far; 34 accepted commands since reset
        rdChk(vfd_pkg::REG_CMD_BAD, 8'h01);
        rdChk(vfd_pkg::REG_LAST_CMD, 8'h20);
        rdChk(vfd_pkg::REG_CMD_OK, 8'h22);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        resetChk();
        results();
    end
    // Whole sequence takes about 3400 cycles; nearly six times that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        results();
    end
endmodule : tb_vfd_ctrl
`default_nettype wire
